/* flash_status_pkg.sv */
// Constants for the second/third status byte and status write logic
// Contract
// - Opcodes 09h and 35h both read status two, even during suspend or resume.
// - Status two repeats its current value while chip select stays low.
// - Status two layout: b7 erase susp, b6 complement, b5..3 locks, b2 prog susp, b1 quad.
// - Erase-suspended flag sets on erase suspend, clears on erase resume.
// - Program-suspended flag sets on program suspend, clears on program resume.
// - Indicator bits clear at power-up and after any reset.
// - Security locks are set-only; a set lock forbids program and erase of its sector.
// - Complement bit defaults 0 and joins the protect bits in region choice.
// - Quad enable 0 keeps protect and hold/reset pins active; 1 disables them.
// - Quad I/O read and quad-mode entry run regardless of quad enable.
// - Opcodes 95h and 15h read status three, repeated while selected.
// - Drive field: 00 67%, 01 100%, 10 half, 11 one third.
// - Wrap field: 00 8, 01 16, 10 32, 11 64 bytes.
// - Blank bit reads 1 fresh, clears forever on any program.
// - Pin switch picks hold or reset only while quad enable is 0.
// - Status write needs the write-enable latch set beforehand, else refused.
// - Status write ends exactly after 8, 16 or 32 data bits, else discarded.
// - Status write never alters busy and latch bits from its data.
// - Valid status write starts timed busy cycle; end clears busy and latch.
// - Status write updates protect-size bits and status-protect bit.
// - Status writes are ignored in hardware protected mode.
// - Hardware protected mode is status-protect 1 with protect pin low.
// - After volatile enable, status write updates volatile copies only, no latch needed; the code also ORs the lock bits into the shadow.
package flash_status_pkg;
    localparam int BYTE_W = 8;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
    localparam logic [7:0] OP_READ_ONE = 8'h05;
    localparam logic [7:0] OP_READ_TWO_A = 8'h09;
    localparam logic [7:0] OP_READ_TWO_B = 8'h35;
    localparam logic [7:0] OP_READ_THREE_A = 8'h95;
    localparam logic [7:0] OP_READ_THREE_B = 8'h15;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_QUAD_MODE_ENTRY = 8'h38;
    // Status one positions
    localparam int BUSY_POS = 0;
    localparam int LATCH_POS = 1;
    localparam int SRP_POS = 7;
    // Status two positions
    localparam int ERASE_SUSP_POS = 7;
    localparam int CMP_POS = 6;
    localparam int LOCK_HI = 5;
    localparam int LOCK_LO = 3;
    localparam int PROG_SUSP_POS = 2;
    localparam int QE_POS = 1;
    // Status three positions
    localparam int PIN_FUNCTION_SWITCH_POS = 7;
    localparam int DRIVE_HI = 6;
    localparam int DRIVE_LO = 5;
    localparam int WRAP_HI = 4;
    localparam int WRAP_LO = 3;
    localparam int BLANK_POS = 2;
    // Reset values
    localparam logic [7:0] ONE_RESET = 8'h00;
    localparam logic [7:0] TWO_RESET = 8'h00;
    localparam logic [7:0] THREE_RESET = 8'h04;
    // Legal data lengths of a status write
    localparam logic [5:0] LEN_ONE = 6'h08;
    localparam logic [5:0] LEN_TWO = 6'h10;
    localparam logic [5:0] LEN_THREE = 6'h20;
    // Self-timed status write cycle
    localparam int CLK_MHZ = 100;
    localparam int STATUS_WRITE_NS = 10000;
    localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_W = 16;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_READ, ST_WDATA, ST_IGNORE
    } link_state_e;
endpackage

/* flash_status_reg.sv */
// Status bytes two/three and status write engine of a serial flash
`timescale 1ns/1ps
module flash_status_reg (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic spiClk,
    input wire logic chipSelN,
    input wire logic dataIn,
    output logic dataOut,
    output logic dataOutEn,
    input wire logic protectPinN,
    input wire logic holdResetPinN,
    input wire logic eraseSuspend,
    input wire logic eraseResume,
    input wire logic programSuspend,
    input wire logic programResume,
    input wire logic byteProgrammed,
    output logic [flash_status_pkg::BYTE_W-1:0] statusOne,
    output logic [flash_status_pkg::BYTE_W-1:0] statusTwo,
    output logic [flash_status_pkg::BYTE_W-1:0] statusThree,
    output logic [5:0] protectConfig,
    output logic [2:0] lockedSectors,
    output logic [6:0] drivePercent,
    output logic [6:0] wrapBytes,
    output logic holdActive,
    output logic pinResetActive,
    output logic hardwareProtected,
    output logic quadCmdAccepted
);
    import flash_status_pkg::*;

    typedef struct packed {
        // Pin synchronisers; the third stage only keeps edge history
        logic csS1;
        logic csS2;
        logic csS3;
        logic sckS1;
        logic sckS2;
        logic sckS3;
        logic diS1;
        logic diS2;
        logic wpS1;
        logic wpS2;
        logic hrS1;
        logic hrS2;
        link_state_e st;
        logic [2:0] opCnt;
        logic [7:0] opcode;
        logic [7:0] shiftIn;
        logic [5:0] dCnt;
        logic [7:0] wb1;
        logic [7:0] wb2;
        logic [7:0] wb3;
        logic [1:0] wLen;
        logic [7:0] outByte;
        logic [2:0] outIdx;
        logic dout;
        logic oe;
        logic [BUSY_W-1:0] busyCnt;
        logic write_in_progress;
        logic write_enable_latch;
        logic volEn;
        // Live status copies and the shadows restored by the reset pin
        logic [7:2] one;
        logic [7:2] nvOne;
        logic [7:0] two;
        logic [7:0] nvTwo;
        logic [7:0] three;
        logic [7:0] nvThree;
        logic quadPulse;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    // Writable status-one bits only; busy and latch never come from data
    function automatic logic [7:2] mergeOne(input logic [7:0] w);
        mergeOne = w[7:2];
    endfunction

    // Locks only ever gain bits; a zero in the data cannot clear one
    function automatic logic [7:0] mergeTwo(input logic [7:0] old, input logic [7:0] w);
        logic [7:0] r;
        r = old;
        r[CMP_POS] = w[CMP_POS];
        r[LOCK_HI:LOCK_LO] = old[LOCK_HI:LOCK_LO] | w[LOCK_HI:LOCK_LO];
        r[QE_POS] = w[QE_POS];
        r[0] = 1'b0;
        mergeTwo = r;
    endfunction

    // Blank indicator is kept, reserved low bits read zero
    function automatic logic [7:0] mergeThree(input logic [7:0] old, input logic [7:0] w);
        mergeThree = {w[PIN_FUNCTION_SWITCH_POS:WRAP_LO], old[BLANK_POS], 2'b00};
    endfunction

    function automatic logic [6:0] driveOf(input logic [1:0] c);
        case (c)
            2'b00: driveOf = 7'h43;
            2'b01: driveOf = 7'h64;
            2'b10: driveOf = 7'h32;
            default: driveOf = 7'h21;
        endcase
    endfunction

    logic qeNow;
    logic hardware_protected_mode;
    logic holdNow;
    logic pinRst;
    logic sckRise;
    logic sckFall;
    logic csRise;
    logic csFall;
    logic [7:0] curOne;
    logic [7:0] inByte;
    logic [7:0] rdByte;

    always_comb begin
        s_nxt = s_r;
        qeNow = s_r.two[QE_POS];
        // Protect and hold/reset pin functions only exist with quad enable low
        hardware_protected_mode = s_r.one[SRP_POS] & ~s_r.wpS2 & ~qeNow;
        holdNow = ~qeNow & ~s_r.three[PIN_FUNCTION_SWITCH_POS] & ~s_r.hrS2 & ~s_r.csS2;
        pinRst = ~qeNow & s_r.three[PIN_FUNCTION_SWITCH_POS] & ~s_r.hrS2;
        // Hold freezes both strobes, so shifting resumes where it stopped
        sckRise = s_r.sckS2 & ~s_r.sckS3 & ~s_r.csS2 & ~holdNow;
        sckFall = ~s_r.sckS2 & s_r.sckS3 & ~s_r.csS2 & ~holdNow;
        csRise = s_r.csS2 & ~s_r.csS3;
        csFall = ~s_r.csS2 & s_r.csS3;
        curOne = {s_r.one, s_r.write_enable_latch, s_r.write_in_progress};
        inByte = {s_r.shiftIn[6:0], s_r.diS2};
        rdByte = s_r.outByte;

        s_nxt.csS1 = chipSelN;
        s_nxt.csS2 = s_r.csS1;
        s_nxt.csS3 = s_r.csS2;
        s_nxt.sckS1 = spiClk;
        s_nxt.sckS2 = s_r.sckS1;
        s_nxt.sckS3 = s_r.sckS2;
        s_nxt.diS1 = dataIn;
        s_nxt.diS2 = s_r.diS1;
        s_nxt.wpS1 = protectPinN;
        s_nxt.wpS2 = s_r.wpS1;
        s_nxt.hrS1 = holdResetPinN;
        s_nxt.hrS2 = s_r.hrS1;
        s_nxt.quadPulse = 1'b0;

        if (csFall) begin
            s_nxt.st = ST_OPCODE;
            s_nxt.opCnt = 3'd0;
            s_nxt.dCnt = 6'd0;
        end

        if (sckRise) begin
            s_nxt.shiftIn = inByte;
            case (s_r.st)
                ST_OPCODE: begin
                    s_nxt.opCnt = s_r.opCnt + 3'd1;
                    if (s_r.opCnt == 3'd7) begin
                        s_nxt.opcode = inByte;
                        s_nxt.outIdx = 3'd0;
                        s_nxt.st = ST_IGNORE;
                        case (inByte)
                            OP_READ_ONE, OP_READ_TWO_A, OP_READ_TWO_B,
                            OP_READ_THREE_A, OP_READ_THREE_B: begin
                                s_nxt.st = ST_READ;
                            end
                            OP_WRITE_STATUS: begin
                                s_nxt.st = ST_WDATA;
                            end
                            // Only flagged here; their data phase lives elsewhere
                            OP_QUAD_IO_READ, OP_QUAD_MODE_ENTRY: begin
                                s_nxt.quadPulse = ~s_r.write_in_progress;
                            end
                            default: begin
                                s_nxt.st = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_WDATA: begin
                    // Saturates, so an overlong write never wraps to a legal length
                    if (s_r.dCnt != 6'h3F) begin
                        s_nxt.dCnt = s_r.dCnt + 6'd1;
                    end
                    if (s_r.dCnt[2:0] == 3'd7) begin
                        case (s_r.dCnt[5:3])
                            3'd0: s_nxt.wb1 = inByte;
                            3'd1: s_nxt.wb2 = inByte;
                            3'd2: s_nxt.wb3 = inByte;
                            default: s_nxt.wb3 = s_r.wb3;
                        endcase
                    end
                end
                default: s_nxt.st = s_r.st;
            endcase
        end

        // Each byte is latched whole at its first bit, so it is never torn
        if (sckFall && s_r.st == ST_READ) begin
            if (s_r.outIdx == 3'd0) begin
                case (s_r.opcode)
                    OP_READ_ONE: rdByte = curOne;
                    OP_READ_TWO_A, OP_READ_TWO_B: rdByte = s_r.two;
                    default: rdByte = s_r.three;
                endcase
                s_nxt.outByte = rdByte;
            end
            s_nxt.dout = rdByte[3'd7 - s_r.outIdx];
            s_nxt.outIdx = s_r.outIdx + 3'd1;
            s_nxt.oe = 1'b1;
        end

        // Commands other than reads and the quad ones act only at chip select rise, so a cut frame does nothing
        if (csRise) begin
            s_nxt.oe = 1'b0;
            s_nxt.st = ST_IDLE;
            if (s_r.st == ST_IGNORE && !s_r.write_in_progress) begin
                case (s_r.opcode)
                    OP_WRITE_ENABLE: s_nxt.write_enable_latch = 1'b1;
                    OP_WRITE_DISABLE: s_nxt.write_enable_latch = 1'b0;
                    OP_VOLATILE_ENABLE: s_nxt.volEn = 1'b1;
                    default: s_nxt.volEn = 1'b0;
                endcase
            end else if (s_r.st == ST_WDATA) begin
                s_nxt.volEn = 1'b0;
                // Length, protection and enable all gate the write
                if ((s_r.dCnt == LEN_ONE || s_r.dCnt == LEN_TWO ||
                     s_r.dCnt == LEN_THREE) && !hardware_protected_mode && !s_r.write_in_progress) begin
                    s_nxt.wLen = s_r.dCnt == LEN_ONE ? 2'd1 :
                                 s_r.dCnt == LEN_TWO ? 2'd2 : 2'd3;
                    if (s_r.volEn) begin
                        // Volatile copies change at once, latch not needed
                        s_nxt.one = mergeOne(s_r.wb1);
                        if (s_r.dCnt != LEN_ONE) begin
                            s_nxt.two = mergeTwo(s_r.two, s_r.wb2);
                            // Locks are one-time bits, so the shadow keeps them too
                            s_nxt.nvTwo[LOCK_HI:LOCK_LO] = s_r.nvTwo[LOCK_HI:LOCK_LO] |
                                s_r.wb2[LOCK_HI:LOCK_LO];
                        end
                        if (s_r.dCnt == LEN_THREE) begin
                            s_nxt.three = mergeThree(s_r.three, s_r.wb3);
                        end
                    end else if (s_r.write_enable_latch) begin
                        s_nxt.write_in_progress = 1'b1;
                        s_nxt.busyCnt = BUSY_W'(STATUS_WRITE_CYC);
                    end
                end
            end else if (s_r.st == ST_READ) begin
                // Volatile enable ends at the next command, except write enable, write disable or one ignored while busy
                s_nxt.volEn = 1'b0;
            end
        end

        // Self-timed cycle; new values land together with busy falling
        if (s_r.write_in_progress) begin
            s_nxt.busyCnt = s_r.busyCnt - BUSY_W'(1);
            if (s_r.busyCnt == BUSY_W'(1)) begin
                s_nxt.write_in_progress = 1'b0;
                s_nxt.write_enable_latch = 1'b0;
                s_nxt.one = mergeOne(s_r.wb1);
                s_nxt.nvOne = mergeOne(s_r.wb1);
                if (s_r.wLen != 2'd1) begin
                    s_nxt.two = mergeTwo(s_r.two, s_r.wb2);
                    s_nxt.nvTwo = mergeTwo(s_r.nvTwo, s_r.wb2);
                end
                if (s_r.wLen == 2'd3) begin
                    s_nxt.three = mergeThree(s_r.three, s_r.wb3);
                    s_nxt.nvThree = mergeThree(s_r.nvThree, s_r.wb3);
                end
            end
        end

        // Suspend flags: a set in the same cycle as its clear wins
        if (eraseResume) begin
            s_nxt.two[ERASE_SUSP_POS] = 1'b0;
        end
        if (eraseSuspend) begin
            s_nxt.two[ERASE_SUSP_POS] = 1'b1;
        end
        if (programResume) begin
            s_nxt.two[PROG_SUSP_POS] = 1'b0;
        end
        if (programSuspend) begin
            s_nxt.two[PROG_SUSP_POS] = 1'b1;
        end
        // No path ever sets blank again, so an erase cannot restore it
        if (byteProgrammed) begin
            s_nxt.three[BLANK_POS] = 1'b0;
            s_nxt.nvThree[BLANK_POS] = 1'b0;
        end

        // Reset pin: volatile copies fall back, indicators clear
        if (pinRst) begin
            s_nxt.one = s_r.nvOne;
            s_nxt.two = s_r.nvTwo;
            s_nxt.three = s_r.nvThree;
            s_nxt.two[ERASE_SUSP_POS] = 1'b0;
            s_nxt.two[PROG_SUSP_POS] = 1'b0;
            s_nxt.write_enable_latch = 1'b0;
            s_nxt.volEn = 1'b0;
            s_nxt.st = ST_IDLE;
            s_nxt.oe = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            // Synchronisers start at each pin's idle level, so no false edge
            s_r.csS1 <= 1'b1;
            s_r.csS2 <= 1'b1;
            s_r.csS3 <= 1'b1;
            s_r.wpS1 <= 1'b1;
            s_r.wpS2 <= 1'b1;
            s_r.hrS1 <= 1'b1;
            s_r.hrS2 <= 1'b1;
            s_r.st <= ST_IDLE;
            s_r.one <= ONE_RESET[7:2];
            s_r.nvOne <= ONE_RESET[7:2];
            s_r.two <= TWO_RESET;
            s_r.nvTwo <= TWO_RESET;
            s_r.three <= THREE_RESET;
            s_r.nvThree <= THREE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Decodes are plain views of the registered status bytes
    assign dataOut = s_r.dout;
    assign dataOutEn = s_r.oe & ~s_r.csS2;
    assign statusOne = {s_r.one, s_r.write_enable_latch, s_r.write_in_progress};
    assign statusTwo = s_r.two;
    assign statusThree = s_r.three;
    assign protectConfig = {s_r.two[CMP_POS], s_r.one[6:2]};
    assign lockedSectors = s_r.two[LOCK_HI:LOCK_LO];
    assign drivePercent = driveOf(s_r.three[DRIVE_HI:DRIVE_LO]);
    assign wrapBytes = 7'h08 << s_r.three[WRAP_HI:WRAP_LO];
    assign holdActive = ~s_r.two[QE_POS] & ~s_r.three[PIN_FUNCTION_SWITCH_POS] & ~s_r.hrS2;
    assign pinResetActive = ~s_r.two[QE_POS] & s_r.three[PIN_FUNCTION_SWITCH_POS] & ~s_r.hrS2;
    assign hardwareProtected = s_r.one[SRP_POS] & ~s_r.wpS2 & ~s_r.two[QE_POS];
    assign quadCmdAccepted = s_r.quadPulse;
endmodule // flash_status_reg

/* spi_host_model.sv */
// Behavioural single-bit host driving the serial link
`timescale 1ns/1ps
module spi_host_model (
    input wire logic sys_clk,
    input wire logic dataOut,
    output logic spiClk,
    output logic chipSelN,
    output logic dataIn
);
    initial begin
        spiClk = 1'b0;
        chipSelN = 1'b1;
        dataIn = 1'b0;
    end
    // Half period of 4 sys_clk; clock rests low outside frames
    task automatic xfer(input logic [39:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        chipSelN = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < n * 8; i++) begin
            spiClk = 1'b0;
            dataIn = tx[39];
            tx = tx << 1;
            repeat (4) @(negedge sys_clk);
            spiClk = 1'b1;
            repeat (4) @(negedge sys_clk);
            // Late in the high phase, past the sync delay
            rx = {rx[14:0], dataOut};
        end
        spiClk = 1'b0;
        repeat (4) @(negedge sys_clk);
        chipSelN = 1'b1;
        // No pull on the line, so show the inverse
        dataIn = ~dataIn;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule // spi_host_model

/* flash_status_reg_properties.sv */
// Concurrent checks on the status byte ports
`timescale 1ns/1ps
module flash_status_reg_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic eraseSuspend,
    input wire logic programSuspend,
    input wire logic programResume,
    input wire logic [flash_status_pkg::BYTE_W-1:0] statusOne,
    input wire logic [flash_status_pkg::BYTE_W-1:0] statusTwo,
    input wire logic [flash_status_pkg::BYTE_W-1:0] statusThree,
    input wire logic [2:0] lockedSectors,
    input wire logic [6:0] drivePercent,
    input wire logic [6:0] wrapBytes
);
    import flash_status_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_reserved; statusTwo[0] == 1'b0; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_lockKeep; (lockedSectors & $past(lockedSectors)) == $past(lockedSectors); endproperty
    a_lockKeep: assert property (p_lockKeep) else $error("lock cleared");
    property p_eraseSet; eraseSuspend |-> ##[1:2] statusTwo[7]; endproperty
    a_eraseSet: assert property (p_eraseSet) else $error("erase flag late");
    property p_progClr; programResume && !programSuspend |-> ##[1:2] !statusTwo[2]; endproperty
    a_progClr: assert property (p_progClr) else $error("program flag stuck");
    property p_blankKeep; !statusThree[2] |=> !statusThree[2]; endproperty
    a_blankKeep: assert property (p_blankKeep) else $error("blank bit came back");
    // Guarded by stability so a registered decode also passes
    property p_drive;
        $stable(statusThree) |-> drivePercent == (statusThree[6] ?
            (statusThree[5] ? 7'h21 : 7'h32) : (statusThree[5] ? 7'h64 : 7'h43));
    endproperty
    a_drive: assert property (p_drive) else $error("drive decode wrong");
    property p_wrap; $stable(statusThree) |-> wrapBytes == (7'h08 << statusThree[4:3]); endproperty
    a_wrap: assert property (p_wrap) else $error("wrap decode wrong");
    property p_busyEnd; $fell(statusOne[0]) |-> !statusOne[1]; endproperty
    a_busyEnd: assert property (p_busyEnd) else $error("latch kept after busy");
    c_write: cover property ($fell(statusOne[0]));
    c_erase: cover property ($rose(statusTwo[7]));
    c_prog: cover property ($rose(statusTwo[2]));
endmodule // flash_status_reg_checker
bind flash_status_reg flash_status_reg_checker propCheck (.sys_clk(sys_clk), .nrst(nrst),
    .eraseSuspend(eraseSuspend), .programSuspend(programSuspend),
    .programResume(programResume), .statusOne(statusOne), .statusTwo(statusTwo),
    .statusThree(statusThree), .lockedSectors(lockedSectors),
    .drivePercent(drivePercent), .wrapBytes(wrapBytes));

/* test_flash_status_reg.sv */
// Self-checking bench for the status two/three and status write logic
`timescale 1ns/1ps
module test_flash_status_reg;
    import flash_status_pkg::*;
    typedef struct {string name; logic [7:0] exp;} note_s;
    logic sys_clk, nrst, spiClk, chipSelN, dataIn, dataOut, protectPinN, holdResetPinN;
    logic eraseSuspend, eraseResume, programSuspend, programResume, byteProgrammed;
    logic hardwareProtected, holdActive, pinResetActive, quadCmdAccepted, dataOutEn;
    logic [5:0] protectConfig;
    logic [2:0] lockedSectors;
    logic [7:0] statusOne, statusTwo, statusThree, resVal;
    logic [6:0] drivePercent, wrapBytes;
    logic [7:0] dTab [4] = '{8'h43, 8'h64, 8'h32, 8'h21};
    logic [15:0] rx;
    note_s q[$];
    note_s cur;
    event resEv;
    int errors, tests_run, cycles, quadSeen, i, w;
    flash_status_reg DUT (.sys_clk(sys_clk), .nrst(nrst), .spiClk(spiClk), .chipSelN(chipSelN),
        .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .protectPinN(protectPinN),
        .holdResetPinN(holdResetPinN), .eraseSuspend(eraseSuspend), .eraseResume(eraseResume),
        .programSuspend(programSuspend), .programResume(programResume),
        .byteProgrammed(byteProgrammed), .statusOne(statusOne), .statusTwo(statusTwo),
        .statusThree(statusThree), .protectConfig(protectConfig), .lockedSectors(lockedSectors),
        .drivePercent(drivePercent), .wrapBytes(wrapBytes), .holdActive(holdActive),
        .pinResetActive(pinResetActive), .hardwareProtected(hardwareProtected),
        .quadCmdAccepted(quadCmdAccepted));
    spi_host_model host (.sys_clk(sys_clk), .dataOut(dataOut), .spiClk(spiClk),
        .chipSelN(chipSelN), .dataIn(dataIn));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (quadCmdAccepted === 1'b1) begin
            quadSeen++;
        end
        if (cycles == 40000) begin
            errors++;
            final_report();
        end
    end
    always @(resEv) begin
        cur = q.pop_front();
        tests_run++;
        if (resVal !== cur.exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", cur.name, cur.exp, resVal);
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
        q.push_back('{n, e});
        resVal = v;
        ->resEv;
        @(negedge sys_clk);
    endtask
    // Opcode then two bytes out, so the repeat is seen too
    task automatic rd(input logic [7:0] op, input logic [7:0] e);
        host.xfer({op, 32'h0}, 3, rx);
        chk("first", e, rx[15:8]);
        chk("repeat", e, rx[7:0]);
    endtask
    task automatic wrs(input logic [31:0] d, input int n, input logic vol);
        host.xfer({(vol ? OP_VOLATILE_ENABLE : OP_WRITE_ENABLE), 32'h0}, 1, rx);
        host.xfer({OP_WRITE_STATUS, d}, n + 1, rx);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 2000 && statusOne[0] !== 1'b0; k++) @(negedge sys_clk);
        chk("busy", 8'h00, {7'h00, statusOne[0]});
    endtask
    initial begin
        {nrst, eraseSuspend, eraseResume, programSuspend, programResume, byteProgrammed} = '0;
        protectPinN = 1'b1;
        holdResetPinN = 1'b1;
        void'($urandom(32'h6164));
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd(OP_READ_TWO_A, 8'h00);
        rd(OP_READ_TWO_B, 8'h00);
        rd(OP_READ_THREE_A, 8'h04);
        rd(OP_READ_THREE_B, 8'h04);
        chk("output enable", 8'h00, {7'h00, dataOutEn});
        $display("test reset_reads done");
        pulse(eraseSuspend);
        rd(OP_READ_TWO_A, 8'h80);
        pulse(programSuspend);
        rd(OP_READ_TWO_B, 8'h84);
        pulse(eraseResume);
        rd(OP_READ_TWO_A, 8'h04);
        pulse(programResume);
        rd(OP_READ_TWO_B, 8'h00);
        $display("test suspend_flags done");
        host.xfer({OP_WRITE_STATUS, 32'hFCFFF800}, 5, rx);
        wait_idle();
        rd(OP_READ_ONE, 8'h00);
        wrs(32'hFCFFF800, 3, 1'b0);
        wait_idle();
        rd(OP_READ_TWO_A, 8'h00);
        $display("test refused_writes done");
        wrs(32'h3FE57BAA, 4, 1'b0);
        rd(OP_READ_ONE, 8'h03);
        wait_idle();
        rd(OP_READ_ONE, 8'h3C);
        rd(OP_READ_TWO_B, 8'h60);
        chk("protect", 8'h2F, {2'b00, protectConfig});
        chk("locks", 8'h04, {5'h00, lockedSectors});
        rd(OP_READ_THREE_A, 8'h7C);
        wrs(32'h00000000, 2, 1'b0);
        wait_idle();
        rd(OP_READ_TWO_A, 8'h20);
        rd(OP_READ_THREE_B, 8'h7C);
        $display("test nonvolatile_writes done");
        for (i = 0; i < 4; i++) begin
            w = $urandom_range(3, 0);
            wrs({16'h0000, 1'b0, i[1:0], w[1:0], 3'b000, 8'h00}, 4, 1'b1);
            chk("drive", dTab[i], {1'b0, drivePercent});
            chk("wrap", 8'h08 << w, {1'b0, wrapBytes});
        end
        $display("test volatile_fields done");
        wrs(32'h80000000, 4, 1'b1);
        protectPinN = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("protected", 8'h01, {7'h00, hardwareProtected});
        wrs(32'h00400000, 4, 1'b1);
        chk("two", 8'h20, statusTwo);
        protectPinN = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk("protected", 8'h00, {7'h00, hardwareProtected});
        pulse(byteProgrammed);
        rd(OP_READ_THREE_B, 8'h00);
        $display("test protect_blank done");
        // Quad enable and reset switch set: pin low must do nothing
        wrs(32'h00028000, 4, 1'b1);
        holdResetPinN = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("pin reset", 8'h00, {7'h00, pinResetActive});
        chk("hold", 8'h00, {7'h00, holdActive});
        host.xfer({OP_QUAD_IO_READ, 32'h0}, 1, rx);
        holdResetPinN = 1'b1;
        wrs(32'h00000000, 4, 1'b1);
        host.xfer({OP_QUAD_MODE_ENTRY, 32'h0}, 1, rx);
        holdResetPinN = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("hold", 8'h01, {7'h00, holdActive});
        holdResetPinN = 1'b1;
        chk("quad", 8'h02, quadSeen[7:0]);
        // Reset pin must restore shadows and clear the suspend flag
        pulse(eraseSuspend);
        wrs(32'h00008000, 4, 1'b1);
        holdResetPinN = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("pin reset two", 8'h20, statusTwo);
        chk("pin reset three", 8'h78, statusThree);
        holdResetPinN = 1'b1;
        repeat (4) @(negedge sys_clk);
        $display("test pin_functions done");
        final_report();
    end
endmodule // test_flash_status_reg
